// file: src/ddts_top.sv
// Inverse sinc, gain, offset, phase trim datapath with multichip sync init
// ==========================================================
// How it works
// [R1] Nine-tap symmetric FIR, taps 2,-4,10,-35,401 mirrored.
// [R2] Inverse sinc off after reset; used only while config bit 9 set.
// [R3] Each channel times its unsigned 9-bit gain over 128.
// [R4] Gain of exactly 0x80 bypasses the multiplier with one less stage.
// [R5] Software should set both gains unity or neither to match latency.
// [R6] Each channel adds its own 16-bit offset to the samples.
// [R7] Offset is signed: 0x8000 up to 0xffff are negative.
// [R8] Samples are two's complement, 0x0000 is midscale.
// [R9] Q is skewed against I by the signed 10-bit phase word.
// [R10] Initialization strobe is exactly one conversion clock wide.
// [R11] Pulse mode strobes on every sync input rising edge.
// [R12] PN mode strobes on every recognised code sequence.
// [R13] Strobe loads clock state machine with the 4-bit initial state field.
// [R14] Clock state machine steps through 32 states, reloads harmlessly.
// [R15] Each field increment advances derived clocks by one period.
// [R16] Pulse mode: transmit gate strobe resets the NCO phase accumulator.
// [R17] PN mode: decoded master phase initializes the NCO accumulator.
// [R18] Pulse mode needs bits 13,12,11 = 0,0,1 and sync input enable.
// [R19] PN mode needs bits 13,12,11 = 1,1,0; bit 25 enables sync out.
// [R20] Gate pin strobe is a low pulse unless the invert bit is set.
// [R21] Correlator is a separate module giving a one-cycle code valid.
`timescale 1ns/1ps

module ddts_pn_corr #(
   parameter logic [15:0] PN_CODE = ddts_pkg::PN_CODE_DEFAULT
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic enable_in,
   input wire logic sync_pin_in,
   output logic code_valid_out
);
   logic [15:0] shift_reg;
   logic code_valid_reg;
   wire logic [15:0] shift_next = {shift_reg[14:0], sync_pin_in};
   wire logic hit = enable_in && (shift_next == PN_CODE);
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         shift_reg <= 16'h0000;
         code_valid_reg <= 1'b0;
      end else if (ce_in) begin
         shift_reg <= shift_next;
         code_valid_reg <= hit; // [R21]
      end
   end
   assign code_valid_out = code_valid_reg;
endmodule

module ddts_top (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic reg_wr_in,
   input wire logic [4:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   output logic [31:0] reg_rdata_out,
   input wire ddts_pkg::ddts_iq_s s_data_in,
   input wire logic s_valid_in,
   output logic s_ready_out,
   output ddts_pkg::ddts_iq_s m_data_out,
   output logic m_valid_out,
   input wire logic m_ready_in,
   input wire logic sync_pin_in,
   input wire logic transmit_gate_pin_in,
   output logic init_strobe_out,
   output logic [4:0] clk_state_out,
   output logic nco_init_out,
   output logic sync_out_en_out
);
   // ==========================================================
   // Helpers
   function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
      if (v > 32'sd32767) begin
         return 16'sh7fff;
      end else if (v < -32'sd32768) begin
         return 16'sh8000;
      end
      return v[15:0];
   endfunction

   function automatic logic signed [15:0] isinc(input logic [143:0] t);
      logic signed [31:0] acc;
      acc = ddts_pkg::ISINC_C1 * ($signed(t[0+:16]) + $signed(t[128+:16]))
         + ddts_pkg::ISINC_C2 * ($signed(t[16+:16]) + $signed(t[112+:16]))
         + ddts_pkg::ISINC_C3 * ($signed(t[32+:16]) + $signed(t[96+:16]))
         + ddts_pkg::ISINC_C4 * ($signed(t[48+:16]) + $signed(t[80+:16]))
         + ddts_pkg::ISINC_C5 * $signed(t[64+:16]); // [R1]
      return sat16(acc >>> ddts_pkg::ISINC_SHIFT);
   endfunction

   function automatic logic signed [15:0] gain_ref(input logic signed [15:0] d, input logic [8:0] g);
      return sat16((32'(d) * $signed({23'h000000, g})) >>> ddts_pkg::GAIN_SHIFT);
   endfunction

   // ==========================================================
   // Registers
   logic [31:0] cfg_reg, sync_reg, phase_reg, gain_reg, off_reg;
   logic [31:0] rdata_reg;
   wire logic wr_cfg = reg_wr_in && reg_addr_in == ddts_pkg::ADDR_DP_SYNC_CFG;
   wire logic wr_sync = reg_wr_in && reg_addr_in == ddts_pkg::ADDR_SYNC_CTRL;
   wire logic wr_phase = reg_wr_in && reg_addr_in == ddts_pkg::ADDR_PHASE_ADJ;
   wire logic wr_gain = reg_wr_in && reg_addr_in == ddts_pkg::ADDR_CH_GAIN;
   wire logic wr_off = reg_wr_in && reg_addr_in == ddts_pkg::ADDR_CH_DC_OFF;
   logic [4:0] clk_state_reg;
   logic init_strobe_reg;
   wire logic [31:0] status_w = {27'h0000000, clk_state_reg};
   wire logic [31:0] rdata_next =
      reg_addr_in == ddts_pkg::ADDR_DP_SYNC_CFG ? cfg_reg :
      reg_addr_in == ddts_pkg::ADDR_SYNC_CTRL ? sync_reg :
      reg_addr_in == ddts_pkg::ADDR_PHASE_ADJ ? phase_reg :
      reg_addr_in == ddts_pkg::ADDR_CH_GAIN ? gain_reg :
      reg_addr_in == ddts_pkg::ADDR_CH_DC_OFF ? off_reg :
      reg_addr_in == ddts_pkg::ADDR_STATUS ? status_w : 32'h0000_0000;

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cfg_reg <= ddts_pkg::RST_DP_SYNC_CFG; // [R2]
         sync_reg <= ddts_pkg::RST_SYNC_CTRL;
         phase_reg <= ddts_pkg::RST_PHASE_ADJ;
         gain_reg <= ddts_pkg::RST_CH_GAIN;
         off_reg <= ddts_pkg::RST_CH_DC_OFF;
         rdata_reg <= 32'h0000_0000;
      end else if (ce_in) begin
         if (wr_cfg) cfg_reg <= reg_wdata_in;
         if (wr_sync) sync_reg <= reg_wdata_in;
         if (wr_phase) phase_reg <= reg_wdata_in;
         if (wr_gain) gain_reg <= reg_wdata_in;
         if (wr_off) off_reg <= reg_wdata_in;
         rdata_reg <= rdata_next;
      end
   end

   wire logic isinc_en = cfg_reg[ddts_pkg::BIT_ISINC_EN];
   wire logic [8:0] gain_i = gain_reg[ddts_pkg::POS_GAIN_I+:9];
   wire logic [8:0] gain_q = gain_reg[ddts_pkg::POS_GAIN_Q+:9];
   wire logic signed [15:0] off_i = off_reg[ddts_pkg::POS_OFF_I+:16]; // [R7]
   wire logic signed [15:0] off_q = off_reg[ddts_pkg::POS_OFF_Q+:16];
   wire logic signed [9:0] phase_w = phase_reg[9:0];
   wire logic [3:0] clk_field = sync_reg[ddts_pkg::POS_CLK_STATE+:4];

   // ==========================================================
   // Two-entry input buffer; a full buffer drops s_ready, but s_ready ignores ce_in, so a word handed over while ce_in is low is lost
   ddts_pkg::ddts_iq_s buf_mem [2];
   logic wr_ptr_reg, rd_ptr_reg, s_ready_reg;
   logic [1:0] count_reg;
   logic m_valid_reg;
   wire logic pe = ce_in && (!m_valid_reg || m_ready_in);
   wire logic push = s_valid_in && s_ready_reg;
   wire logic pop = pe && count_reg != 2'd0;
   wire logic [1:0] count_next = count_reg + {1'b0, push} - {1'b0, pop};
   wire ddts_pkg::ddts_iq_s head = buf_mem[rd_ptr_reg];

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'd0;
         s_ready_reg <= 1'b0;
      end else if (ce_in) begin
         if (push) begin
            buf_mem[wr_ptr_reg] <= s_data_in; // [R8]
            wr_ptr_reg <= !wr_ptr_reg;
         end
         if (pop) rd_ptr_reg <= !rd_ptr_reg;
         count_reg <= count_next;
         s_ready_reg <= count_next != 2'd2;
      end
   end

   // ==========================================================
   // Pipeline: inverse sinc, gain, phase and offset
   logic [143:0] taps_i_reg, taps_q_reg;
   logic v1_reg, v2_reg, v3_reg;
   ddts_pkg::ddts_iq_s d1_reg, g3_reg, out_reg;
   logic signed [25:0] p2_i_reg, p2_q_reg;
   wire logic [143:0] taps_i_next = {taps_i_reg[127:0], head.i};
   wire logic [143:0] taps_q_next = {taps_q_reg[127:0], head.q};
   wire logic signed [15:0] s1_i = isinc_en ? isinc(taps_i_next) : head.i; // [R2]
   wire logic signed [15:0] s1_q = isinc_en ? isinc(taps_q_next) : head.q;
   wire logic byp_i = gain_i == ddts_pkg::GAIN_UNITY;
   wire logic byp_q = gain_q == ddts_pkg::GAIN_UNITY;
   wire logic signed [15:0] m_i = sat16(32'(p2_i_reg >>> ddts_pkg::GAIN_SHIFT));
   wire logic signed [15:0] m_q = sat16(32'(p2_q_reg >>> ddts_pkg::GAIN_SHIFT));
   wire logic signed [25:0] skew = g3_reg.i * phase_w;
   wire logic signed [15:0] o_i = sat16(32'(g3_reg.i) + 32'(off_i));
   wire logic signed [15:0] o_q = sat16(32'(g3_reg.q) + 32'(off_q)
      + 32'(skew >>> ddts_pkg::PHASE_SHIFT));

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         taps_i_reg <= '0;
         taps_q_reg <= '0;
         v1_reg <= 1'b0;
         v2_reg <= 1'b0;
         v3_reg <= 1'b0;
         m_valid_reg <= 1'b0;
         d1_reg <= '0;
         p2_i_reg <= '0;
         p2_q_reg <= '0;
         g3_reg <= '0;
         out_reg <= '0;
      end else if (pe) begin
         if (pop) begin
            taps_i_reg <= taps_i_next; // [R1]
            taps_q_reg <= taps_q_next;
         end
         v1_reg <= pop;
         d1_reg <= '{i: s1_i, q: s1_q};
         v2_reg <= v1_reg;
         p2_i_reg <= d1_reg.i * $signed({1'b0, gain_i}); // [R3]
         p2_q_reg <= d1_reg.q * $signed({1'b0, gain_q});
         v3_reg <= v2_reg;
         // Bypass taps the sample one stage earlier, hence its shorter delay
         g3_reg.i <= byp_i ? d1_reg.i : m_i; // [R4]
         g3_reg.q <= byp_q ? d1_reg.q : m_q;
         m_valid_reg <= v3_reg;
         out_reg <= '{i: o_i, q: o_q}; // [R6] [R9]
      end
   end

   // ==========================================================
   // Sync receive and clock generation state
   logic sync_prev_reg, gate_prev_reg, nco_init_reg, sync_oe_reg;
   logic code_valid;
   wire logic sync_en = sync_reg[ddts_pkg::BIT_SYNC_IN_EN];
   wire logic [2:0] mode_bits = {cfg_reg[ddts_pkg::BIT_PN_EN], cfg_reg[ddts_pkg::BIT_MODE_SEL],
      cfg_reg[ddts_pkg::BIT_PULSE_EN]};
   wire logic pulse_mode = sync_en && mode_bits == 3'b001; // [R18]
   wire logic pn_mode = sync_en && mode_bits == 3'b110; // [R19]
   wire logic sync_rise = sync_pin_in && !sync_prev_reg;
   wire logic gate_lvl = transmit_gate_pin_in ^ cfg_reg[ddts_pkg::BIT_GATE_INV]; // [R20]
   wire logic gate_fall = gate_prev_reg && !gate_lvl;
   wire logic strobe_next = (pulse_mode && sync_rise) || (pn_mode && code_valid); // [R11] [R12]
   wire logic [4:0] clk_state_next = init_strobe_reg ? {1'b0, clk_field} // [R13] [R15]
      : clk_state_reg + 5'd1; // [R14]

   ddts_pn_corr u_corr (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .ce_in(ce_in),
      .enable_in(pn_mode),
      .sync_pin_in(sync_pin_in),
      .code_valid_out(code_valid)
   ); // [R21]

   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         sync_prev_reg <= 1'b0;
         gate_prev_reg <= 1'b0;
         init_strobe_reg <= 1'b0;
         clk_state_reg <= 5'd0;
         nco_init_reg <= 1'b0;
         sync_oe_reg <= 1'b0;
      end else if (ce_in) begin
         sync_prev_reg <= sync_pin_in;
         gate_prev_reg <= gate_lvl;
         init_strobe_reg <= strobe_next && !init_strobe_reg; // [R10]
         clk_state_reg <= clk_state_next;
         nco_init_reg <= (pulse_mode && gate_fall) || (pn_mode && code_valid); // [R16] [R17]
         sync_oe_reg <= sync_reg[ddts_pkg::BIT_SYNC_OUT_EN]; // [R19]
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign s_ready_out = s_ready_reg;
   assign m_data_out = out_reg;
   assign m_valid_out = m_valid_reg;
   assign init_strobe_out = init_strobe_reg;
   assign clk_state_out = clk_state_reg;
   assign nco_init_out = nco_init_reg;
   assign sync_out_en_out = sync_oe_reg;

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_state_loaded;
      ce_in && init_strobe_reg ##1 clk_state_reg == {1'b0, $past(clk_field)};
   endsequence

   a_strobe_one_wide: assert property (init_strobe_reg |=> !init_strobe_reg) // [R10]
      else $error("init strobe wider than one cycle");
   a_pulse_edge_strobe: assert property (ce_in && pulse_mode && sync_rise && !init_strobe_reg // [R11]
      |=> init_strobe_reg)
      else $error("sync rising edge gave no strobe");
   a_pn_code_strobe: assert property (ce_in && pn_mode && code_valid && !init_strobe_reg // [R12]
      |=> init_strobe_reg)
      else $error("code valid gave no strobe");
   a_state_load: assert property (ce_in && init_strobe_reg |-> s_state_loaded) // [R13]
      else $error("clock state not loaded from field");
   a_state_wrap: assert property (ce_in && !init_strobe_reg // [R14]
      && clk_state_reg == ddts_pkg::CLK_STATE_LAST |=> clk_state_reg == 5'd0)
      else $error("clock state did not wrap after 32 states");
   a_isinc_reset: assert property ($rose(!rst_in) |-> !isinc_en) // [R2]
      else $error("inverse sinc enabled after reset");
   a_gain_bypass: assert property (pe && byp_i |=> g3_reg.i == $past(d1_reg.i)) // [R4]
      else $error("unity gain did not bypass");
   // Product recomputed from the stage-one sample and the gain in force when it was multiplied
   a_gain_mult: assert property (pe && !byp_i ##1 pe && !byp_i // [R3]
      |=> g3_reg.i == gain_ref($past(d1_reg.i, 2), $past(gain_i, 2)))
      else $error("gain product wrong");
   a_offset_add: assert property (pe |=> m_data_out.i == sat16(32'($past(g3_reg.i)) + 32'($past(off_i)))) // [R6]
      else $error("offset not added");
   a_nco_pulse: assert property (ce_in && pulse_mode && gate_fall |=> nco_init_out) // [R16]
      else $error("gate strobe gave no nco init");
endmodule

// file: src/ddts_pkg.sv
// Shared constants and types for the DAC datapath trim and sync init block
package ddts_pkg;
   // ==========================================================
   // Register map, 5-bit register index
   localparam logic [4:0] ADDR_DP_SYNC_CFG = 5'h01;
   localparam logic [4:0] ADDR_SYNC_CTRL = 5'h03;
   localparam logic [4:0] ADDR_PHASE_ADJ = 5'h0b;
   localparam logic [4:0] ADDR_CH_GAIN = 5'h0c;
   localparam logic [4:0] ADDR_CH_DC_OFF = 5'h0d;
   localparam logic [4:0] ADDR_STATUS = 5'h1e;
   // ==========================================================
   // Field positions
   localparam int BIT_ISINC_EN = 9;
   localparam int BIT_PULSE_EN = 11;
   localparam int BIT_MODE_SEL = 12;
   localparam int BIT_PN_EN = 13;
   localparam int BIT_GATE_INV = 14;
   localparam int BIT_SYNC_IN_EN = 26;
   localparam int BIT_SYNC_OUT_EN = 25;
   localparam int POS_CLK_STATE = 4;
   localparam int POS_GAIN_I = 0;
   localparam int POS_GAIN_Q = 16;
   localparam int POS_OFF_I = 0;
   localparam int POS_OFF_Q = 16;
   // ==========================================================
   // Reset values
   localparam logic [31:0] RST_DP_SYNC_CFG = 32'h0000_0000;
   localparam logic [31:0] RST_SYNC_CTRL = 32'h0000_0000;
   localparam logic [31:0] RST_PHASE_ADJ = 32'h0000_0000;
   localparam logic [31:0] RST_CH_GAIN = 32'h0080_0080;
   localparam logic [31:0] RST_CH_DC_OFF = 32'h0000_0000;
   // ==========================================================
   // Datapath constants
   localparam logic [8:0] GAIN_UNITY = 9'h080;
   localparam int GAIN_SHIFT = 7;
   localparam int ISINC_SHIFT = 9;
   localparam int PHASE_SHIFT = 11;
   localparam logic signed [9:0] ISINC_C1 = 10'sd2;
   localparam logic signed [9:0] ISINC_C2 = -10'sd4;
   localparam logic signed [9:0] ISINC_C3 = 10'sd10;
   localparam logic signed [9:0] ISINC_C4 = -10'sd35;
   localparam logic signed [9:0] ISINC_C5 = 10'sd401;
   localparam logic [4:0] CLK_STATE_LAST = 5'h1f;
   localparam logic [15:0] PN_CODE_DEFAULT = 16'ha5c3;
   // ==========================================================
   typedef struct packed {
      logic signed [15:0] i;
      logic signed [15:0] q;
   } ddts_iq_s;
endpackage

// file: tb/ddts_src_model.sv
// Baseband sample source model that feeds the block's input stream
`timescale 1ns/1ps

module ddts_src_model (
   input wire logic core_clk_in,
   input wire logic s_ready_in,
   output ddts_pkg::ddts_iq_s s_data_out,
   output logic s_valid_out
);
   initial begin
      s_data_out = '0;
      s_valid_out = 1'b0;
   end
   // ==========================================================
   // Handshake
   // The word stays put until ready is seen at a rising edge; a gap first releases the bus
   task automatic send(input ddts_pkg::ddts_iq_s w, input int gap, output bit ok);
      ok = 1'b0;
      if (gap > 0) begin
         idle();
         repeat (gap) @(posedge core_clk_in);
      end
      #1;
      s_data_out = w;
      s_valid_out = 1'b1;
      for (int n = 0; n < 400 && !ok; n++) begin
         @(posedge core_clk_in);
         ok = (s_ready_in === 1'b1);
      end
   endtask
   // Released data shows the inverse of the last word so stale data never looks fresh
   task automatic idle();
      #1;
      s_valid_out = 1'b0;
      s_data_out = ~s_data_out;
   endtask
endmodule

// file: tb/tb_ddts_top.sv
// Self-checking testbench for the datapath trim and sync init block
`timescale 1ns/1ps

module tb_ddts_top;
   logic core_clk_in, rst_in, ce_in, reg_wr_in, m_ready_in, sync_pin_in, transmit_gate_pin_in;
   logic s_valid_in, s_ready_out, m_valid_out, init_strobe_out, nco_init_out, sync_out_en_out;
   logic [4:0] reg_addr_in;
   logic [4:0] clk_state_out;
   logic [31:0] reg_wdata_in;
   logic [31:0] reg_rdata_out;
   logic [31:0] r;
   ddts_pkg::ddts_iq_s s_data_in, m_data_out;
   ddts_pkg::ddts_iq_s got [$];
   int miscompares = 0, n_tests = 0, n_init = 0, n_nco = 0, n_full = 0, b;

   ddts_top i_ddts_top (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in), .reg_wr_in(reg_wr_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
      .s_data_in(s_data_in), .s_valid_in(s_valid_in), .s_ready_out(s_ready_out), .m_data_out(m_data_out),
      .m_valid_out(m_valid_out), .m_ready_in(m_ready_in), .sync_pin_in(sync_pin_in),
      .transmit_gate_pin_in(transmit_gate_pin_in), .init_strobe_out(init_strobe_out),
      .clk_state_out(clk_state_out), .nco_init_out(nco_init_out), .sync_out_en_out(sync_out_en_out));
   ddts_src_model i_ddts_src_model (.core_clk_in(core_clk_in), .s_ready_in(s_ready_out),
      .s_data_out(s_data_in), .s_valid_out(s_valid_in));

   initial begin
      core_clk_in = 1'b0;
      forever #20 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) begin
      if (m_valid_out === 1'b1 && m_ready_in === 1'b1) got.push_back(m_data_out);
      if (init_strobe_out === 1'b1) n_init++;
      if (nco_init_out === 1'b1) n_nco++;
      if (s_valid_in === 1'b1 && s_ready_out !== 1'b1) n_full++;
   end
   // ==========================================================
   // Shared tasks
   task automatic close_out();
      $display("Mismatches %0d, comparisons %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic stuck();
      miscompares++;
      $display("Error at %0t: wait ran out, seen 0x0 expected 0x1", $time);
      close_out();
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_in = 1'b1;
      @(posedge core_clk_in) #1;
      reg_wr_in = 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      reg_addr_in = a;
      @(posedge core_clk_in) #1;
      d = reg_rdata_out;
   endtask
   task automatic push(input logic [15:0] i, input logic [15:0] q, input int gap);
      bit ok;
      i_ddts_src_model.send({i, q}, gap, ok);
      if (!ok) stuck();
   endtask
   task automatic drain(input int n);
      i_ddts_src_model.idle();
      for (int k = 0; k < 400 && got.size() < n; k++) @(posedge core_clk_in);
      #1;
      if (got.size() < n) stuck();
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs();
      rd(ddts_pkg::ADDR_DP_SYNC_CFG, r); check(r, 32'h0000_0000);
      rd(ddts_pkg::ADDR_CH_GAIN, r); check(r, 32'h0080_0080);
      wr(5'h1f, 32'hffff_ffff);
      rd(5'h1f, r); check(r, 32'h0000_0000);
      wr(ddts_pkg::ADDR_PHASE_ADJ, 32'h0000_03ff);
      rd(ddts_pkg::ADDR_PHASE_ADJ, r); check(r, 32'h0000_03ff);
      wr(ddts_pkg::ADDR_PHASE_ADJ, 32'h0000_0000);
   endtask
   task automatic t_stream();
      got.delete();
      wr(ddts_pkg::ADDR_CH_GAIN, 32'h0100_0100);
      fork
         begin
            m_ready_in = 1'b0;
            cyc(20);
            m_ready_in = 1'b1;
         end
      join_none
      for (int k = 0; k < 8; k++) push(16'h1234 + 16'(k), 16'hc000 + 16'(k), 0);
      push(16'h0000, 16'h7fff, 3);
      drain(9);
      check(32'(n_full != 0), 32'h1);
      for (int k = 0; k < 8; k++) check(got[k], {16'h2468 + 16'(2 * k), 16'h8000 + 16'(2 * k)});
      check(got[8], 32'h0000_7fff);
   endtask
   task automatic t_bypass();
      got.delete();
      wr(ddts_pkg::ADDR_CH_GAIN, 32'h0080_0080);
      push(16'h0123, 16'h0456, 0);
      push(16'h0789, 16'h0abc, 0);
      drain(2);
      // Unity gain skips the multiplier stage, so the first slot already holds the newer word
      check(got[0], 32'h0789_0abc);
   endtask
   task automatic t_trim(input logic [4:0] a, input logic [31:0] v, input logic [31:0] s, input logic [31:0] e);
      got.delete();
      wr(a, v);
      // Two equal words, so the shorter bypass path shows the same value as the multiplier path
      push(s[31:16], s[15:0], 0);
      push(s[31:16], s[15:0], 0);
      drain(2);
      check(got[0], e);
      check(got[1], e);
   endtask
   task automatic t_isinc();
      got.delete();
      wr(ddts_pkg::ADDR_DP_SYNC_CFG, 32'h0000_0200);
      for (int k = 0; k < 12; k++) push(16'h0200, 16'hfe00, 0);
      drain(12);
      check(got[11], 32'h015b_fea5);
      wr(ddts_pkg::ADDR_DP_SYNC_CFG, 32'h0000_0000);
   endtask
   task automatic t_pulse(input logic [3:0] f);
      wr(ddts_pkg::ADDR_DP_SYNC_CFG, 32'h0000_0800);
      wr(ddts_pkg::ADDR_SYNC_CTRL, 32'h0600_0000 | (32'(f) << 4));
      sync_pin_in = 1'b1;
      for (int k = 0; k < 8 && init_strobe_out !== 1'b1; k++) cyc(1);
      check(32'(init_strobe_out), 32'h1);
      check(32'(sync_out_en_out), 32'h1);
      cyc(1);
      b = n_init;
      check(32'(init_strobe_out), 32'h0);
      check(32'(clk_state_out), 32'(f));
      cyc(1);
      check(32'(clk_state_out), 32'(f) + 32'h1);
      ce_in = 1'b0;
      cyc(3);
      check(32'(clk_state_out), 32'(f) + 32'h1);
      ce_in = 1'b1;
      cyc(32);
      check(32'(clk_state_out), 32'(f) + 32'h1);
      rd(ddts_pkg::ADDR_STATUS, r);
      check(r, 32'(f) + 32'h1);
      check(32'(n_init - b), 32'h0);
      sync_pin_in = 1'b0;
      b = n_nco;
      transmit_gate_pin_in = 1'b0;
      cyc(1);
      transmit_gate_pin_in = 1'b1;
      cyc(4);
      check(32'(n_nco - b), 32'h1);
      wr(ddts_pkg::ADDR_DP_SYNC_CFG, 32'h0000_4800);
      transmit_gate_pin_in = 1'b0;
      cyc(2);
      transmit_gate_pin_in = 1'b1;
      cyc(4);
      check(32'(n_nco - b), 32'h2);
      wr(ddts_pkg::ADDR_SYNC_CTRL, 32'h0000_0000);
      b = n_init;
      sync_pin_in = 1'b1;
      cyc(4);
      sync_pin_in = 1'b0;
      check(32'(n_init - b), 32'h0);
   endtask
   task automatic t_pn();
      logic [31:0] code;
      code = 32'ha5c3_c3a5;
      wr(ddts_pkg::ADDR_DP_SYNC_CFG, 32'h0000_3000);
      wr(ddts_pkg::ADDR_SYNC_CTRL, 32'h0400_0030);
      check(32'(sync_out_en_out), 32'h0);
      b = n_nco;
      r = 32'(n_init);
      for (int k = 31; k >= 0; k--) begin
         sync_pin_in = code[k];
         cyc(1);
      end
      sync_pin_in = 1'b0;
      cyc(4);
      check(32'(n_init != int'(r)), 32'h1);
      check(32'(n_nco != b), 32'h1);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      rst_in = 1'b1;
      ce_in = 1'b1;
      reg_wr_in = 1'b0;
      reg_addr_in = 5'h00;
      reg_wdata_in = 32'h0000_0000;
      m_ready_in = 1'b1;
      sync_pin_in = 1'b0;
      transmit_gate_pin_in = 1'b1;
      cyc(16);
      rst_in = 1'b0;
      t_regs();
      t_stream();
      t_trim(ddts_pkg::ADDR_CH_GAIN, 32'h0040_0100, 32'h1000_f000, 32'h2000_f800);
      t_trim(ddts_pkg::ADDR_CH_GAIN, 32'h01ff_0000, 32'h1000_0100, 32'h0000_03fe);
      t_trim(ddts_pkg::ADDR_CH_GAIN, 32'h0080_0080, 32'h0000_0000, 32'h0000_0000);
      t_bypass();
      t_trim(ddts_pkg::ADDR_CH_DC_OFF, 32'hfff0_0010, 32'h0100_0100, 32'h0110_00f0);
      t_trim(ddts_pkg::ADDR_CH_DC_OFF, 32'h7fff_8000, 32'h0000_0000, 32'h8000_7fff);
      t_trim(ddts_pkg::ADDR_CH_DC_OFF, 32'h0000_0000, 32'h1000_0000, 32'h1000_0000);
      t_trim(ddts_pkg::ADDR_PHASE_ADJ, 32'h0000_0200, 32'h1000_0000, 32'h1000_fc00);
      t_trim(ddts_pkg::ADDR_PHASE_ADJ, 32'h0000_01ff, 32'h1000_0000, 32'h1000_03fe);
      wr(ddts_pkg::ADDR_PHASE_ADJ, 32'h0000_0000);
      t_isinc();
      t_pulse(4'h5);
      t_pulse(4'hf);
      t_pn();
      close_out();
   end
endmodule
